// >>> hdl/ocr_output_stage.v
// Output clock pin routing: single-ended, differential, duplicate pins,
// auxiliary I/O sharing and frame-sync shaping, with APB registers.
// Assumes synthesized clocks arrive as levels from the synthesis path.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "ocr_defs.vh"

module ocr_output_stage (
	input wire ref_clk, // 100 MHz clock
	input wire sys_rst, // Synchronous reset, high
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output wire pready, // APB ready
	output wire pslverr, // APB error
	input wire rate_family_select, // Rate-family strap pin
	input wire [6:0] synth_clk, // Synthesized clocks a..g
	output reg clk_out_a, // Single-ended a
	output reg clk_out_b, // Single-ended b
	output reg clk_out_c, // Single-ended c
	output reg clk_out_d, // Single-ended d
	output reg clk_out_e, // Single-ended e
	output reg clk_out_d_diff_p, // Diff d positive
	output reg clk_out_d_diff_n, // Diff d negative
	output reg clk_out_e_diff_p, // Diff e positive
	output reg clk_out_e_diff_n, // Diff e negative
	output reg clk_out_f_diff_p, // Diff f positive
	output reg clk_out_f_diff_n, // Diff f negative
	output reg clk_out_g_diff_p, // Diff g positive
	output reg clk_out_g_diff_n, // Diff g negative
	output wire [1:0] diff_d_format, // Format select d
	output wire [1:0] diff_e_format, // Format select e
	output wire [1:0] diff_f_format, // Format select f
	output wire [1:0] diff_g_format, // Format select g
	output wire [19:0] freq_a, // Programmed frequency a, kHz
	output wire [19:0] freq_b, // Programmed frequency b, kHz
	output wire [19:0] freq_c, // Programmed frequency c, kHz
	output wire [19:0] freq_d, // Programmed frequency d, kHz
	output wire [19:0] freq_e, // Programmed frequency e, kHz
	output wire [19:0] freq_f, // Programmed frequency f, kHz
	output wire [19:0] freq_g, // Programmed frequency g, kHz
	input wire [2:0] aux_io_in, // Aux pins one..three input
	output reg [2:0] aux_io_out, // Aux pins one..three output
	output reg [2:0] aux_io_oe, // Aux pins one..three enable
	output reg clk_out_d_dup, // Duplicate d output
	output reg clk_out_d_dup_oe, // Duplicate d enable
	output reg clk_out_e_dup, // Duplicate e output
	output reg clk_out_e_dup_oe, // Duplicate e enable
	output wire frame_sync_out, // 8 kHz sync
	output wire multiframe_sync_out // 2 kHz sync
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg [4:0] output_dup_control;
	reg [7:0] diff_format_control;
	reg [3:0] frame_sync_control;
	reg [19:0] freq [0:6];
	reg [2:0] gpio_dir;
	reg [2:0] gpio_val;
	reg rate_meta;
	reg rate_sync;
	reg rate_family;
	reg rst_d;
	reg [6:0] clk_meta;
	reg [6:0] clk_sync;
	reg [2:0] aux_meta;
	reg [2:0] aux_sync;

	wire dup_a_enable = output_dup_control[0];
	wire dup_b_enable = output_dup_control[1];
	wire dup_c_enable = output_dup_control[2];
	wire dup_d_enable = output_dup_control[3];
	wire dup_e_enable = output_dup_control[4];
	wire [2:0] dup_abc = {dup_c_enable, dup_b_enable, dup_a_enable};
	wire wr_en = psel & penable & pwrite;

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign diff_d_format = diff_format_control[1:0];
	assign diff_e_format = diff_format_control[3:2];
	assign diff_f_format = diff_format_control[5:4];
	assign diff_g_format = diff_format_control[7:6];
	assign freq_a = freq[0];
	assign freq_b = freq[1];
	assign freq_c = freq[2];
	assign freq_d = freq[3];
	assign freq_e = freq[4];
	assign freq_f = freq[5];
	assign freq_g = freq[6];

	// ----------------------------------------------------------------
	// Input synchronisers and rate strap
	// ----------------------------------------------------------------
	// Strap is caught on the first edge after reset releases
	always @(posedge ref_clk) begin
		rate_meta <= rate_family_select;
		rate_sync <= rate_meta;
		clk_meta <= synth_clk;
		clk_sync <= clk_meta;
		aux_meta <= aux_io_in;
		aux_sync <= aux_meta;
		if (sys_rst) begin
			rst_d <= 1'b1;
			rate_family <= 1'b0;
		end else begin
			rst_d <= 1'b0;
			if (rst_d) begin
				rate_family <= rate_sync;
			end
		end
	end

	// ----------------------------------------------------------------
	// APB register file
	// ----------------------------------------------------------------
	// Frequency e default is loaded with the strap, one cycle after release
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			output_dup_control <= `OCR_DUP_RESET;
			diff_format_control <= `OCR_FMT_RESET;
			frame_sync_control <= `OCR_FS_RESET;
			freq[0] <= `OCR_FREQ_A_RST;
			freq[1] <= `OCR_FREQ_B_RST;
			freq[2] <= `OCR_FREQ_C_RST;
			freq[3] <= `OCR_FREQ_D_RST;
			freq[4] <= `OCR_FREQ_E_SDH;
			freq[5] <= `OCR_FREQ_F_RST;
			freq[6] <= `OCR_FREQ_G_RST;
			gpio_dir <= 3'h0;
			gpio_val <= 3'h0;
		end else if (rst_d) begin
			freq[4] <= rate_sync ? `OCR_FREQ_E_SONET : `OCR_FREQ_E_SDH;
		end else if (wr_en) begin
			case (paddr)
				`OCR_ADDR_DUP_CTRL: output_dup_control <= pwdata[4:0];
				`OCR_ADDR_FMT_CTRL: diff_format_control <= pwdata[7:0];
				`OCR_ADDR_FS_CTRL: frame_sync_control <= pwdata[3:0];
				`OCR_ADDR_FREQ_A: freq[0] <= pwdata[19:0];
				`OCR_ADDR_FREQ_B: freq[1] <= pwdata[19:0];
				`OCR_ADDR_FREQ_C: freq[2] <= pwdata[19:0];
				`OCR_ADDR_FREQ_D: freq[3] <= pwdata[19:0];
				`OCR_ADDR_FREQ_E: freq[4] <= pwdata[19:0];
				`OCR_ADDR_FREQ_F: freq[5] <= pwdata[19:0];
				`OCR_ADDR_FREQ_G: freq[6] <= pwdata[19:0];
				`OCR_ADDR_GPIO: begin
					gpio_dir <= pwdata[2:0];
					gpio_val <= pwdata[6:4];
				end
				default: begin
				end
			endcase
		end
	end

	// Read data is caught in the setup cycle, so it comes from a flop
	// and pready can still stay high with no wait state
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			prdata <= 32'h00000000;
		end else if (psel & ~penable) begin
			case (paddr)
				`OCR_ADDR_DUP_CTRL: prdata <= {27'h0, output_dup_control};
				`OCR_ADDR_FMT_CTRL: prdata <= {24'h0, diff_format_control};
				`OCR_ADDR_FS_CTRL: prdata <= {28'h0, frame_sync_control};
				`OCR_ADDR_FREQ_A: prdata <= {12'h0, freq[0]};
				`OCR_ADDR_FREQ_B: prdata <= {12'h0, freq[1]};
				`OCR_ADDR_FREQ_C: prdata <= {12'h0, freq[2]};
				`OCR_ADDR_FREQ_D: prdata <= {12'h0, freq[3]};
				`OCR_ADDR_FREQ_E: prdata <= {12'h0, freq[4]};
				`OCR_ADDR_FREQ_F: prdata <= {12'h0, freq[5]};
				`OCR_ADDR_FREQ_G: prdata <= {12'h0, freq[6]};
				`OCR_ADDR_STATUS: prdata <= {28'h0, aux_sync, rate_family};
				`OCR_ADDR_GPIO: prdata <= {25'h0, gpio_val, 1'b0, gpio_dir};
				default: prdata <= 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Clock routing
	// ----------------------------------------------------------------
	// Registered so every pin pair shares one edge; adds one cycle of lag, three in all from synth_clk
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			clk_out_a <= 1'b0;
			clk_out_b <= 1'b0;
			clk_out_c <= 1'b0;
			clk_out_d <= 1'b0;
			clk_out_e <= 1'b0;
			clk_out_d_diff_p <= 1'b0;
			clk_out_d_diff_n <= 1'b1;
			clk_out_e_diff_p <= 1'b0;
			clk_out_e_diff_n <= 1'b1;
			clk_out_f_diff_p <= 1'b0;
			clk_out_f_diff_n <= 1'b1;
			clk_out_g_diff_p <= 1'b0;
			clk_out_g_diff_n <= 1'b1;
			clk_out_d_dup <= 1'b0;
			clk_out_d_dup_oe <= 1'b0;
			clk_out_e_dup <= 1'b0;
			clk_out_e_dup_oe <= 1'b0;
		end else begin
			clk_out_a <= clk_sync[0];
			clk_out_b <= clk_sync[1];
			clk_out_c <= clk_sync[2];
			clk_out_d <= clk_sync[3];
			clk_out_e <= clk_sync[4];
			clk_out_d_diff_p <= clk_sync[3];
			clk_out_d_diff_n <= ~clk_sync[3];
			clk_out_e_diff_p <= clk_sync[4];
			clk_out_e_diff_n <= ~clk_sync[4];
			clk_out_f_diff_p <= clk_sync[5];
			clk_out_f_diff_n <= ~clk_sync[5];
			clk_out_g_diff_p <= clk_sync[6];
			clk_out_g_diff_n <= ~clk_sync[6];
			clk_out_d_dup <= dup_d_enable & clk_sync[3];
			clk_out_d_dup_oe <= dup_d_enable;
			clk_out_e_dup <= dup_e_enable & clk_sync[4];
			clk_out_e_dup_oe <= dup_e_enable;
		end
	end

	// ----------------------------------------------------------------
	// Auxiliary pins: duplicate clock or general-purpose I/O
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_aux
			always @(posedge ref_clk) begin
				if (sys_rst) begin
					aux_io_out[gi] <= 1'b0;
					aux_io_oe[gi] <= 1'b0;
				end else if (dup_abc[gi]) begin
					aux_io_out[gi] <= clk_sync[gi];
					aux_io_oe[gi] <= 1'b1;
				end else begin
					aux_io_out[gi] <= gpio_val[gi];
					aux_io_oe[gi] <= gpio_dir[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Frame-sync timebase
	// ----------------------------------------------------------------
	reg [13:0] fs_cnt;
	reg [1:0] mf_cnt;
	wire fs_wrap = (fs_cnt == `OCR_FS8K_LAST);
	wire fs_half = (fs_cnt >= `OCR_FS8K_HALF);
	wire mf_start = fs_wrap & (mf_cnt == `OCR_FS_MF_LAST);
	wire mf_half = mf_cnt[1];

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			fs_cnt <= 14'h0000;
			mf_cnt <= 2'h0;
		end else if (fs_wrap) begin
			fs_cnt <= 14'h0000;
			mf_cnt <= mf_cnt + 2'h1;
		end else begin
			fs_cnt <= fs_cnt + 14'h0001;
		end
	end

	ocr_frame_sync u_fs8k (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.period_start(fs_wrap),
		.second_half(fs_half),
		.invert(frame_sync_control[`OCR_FS_8K_INV]),
		.pulse_mode(frame_sync_control[`OCR_FS_8K_PUL]),
		.sync_out(frame_sync_out)
	);

	ocr_frame_sync u_fs2k (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.period_start(mf_start),
		.second_half(mf_half),
		.invert(frame_sync_control[`OCR_FS_2K_INV]),
		.pulse_mode(frame_sync_control[`OCR_FS_2K_PUL]),
		.sync_out(multiframe_sync_out)
	);

endmodule // ocr_output_stage

// >>> hdl/ocr_defs.vh
// Constants for the output clock pin routing block.
// Assumes a 100 MHz ref_clk and 32-bit APB with word-aligned registers.
`ifndef OCR_DEFS_VH
`define OCR_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OCR_ADDR_DUP_CTRL 12'h000
`define OCR_ADDR_FMT_CTRL 12'h004
`define OCR_ADDR_FS_CTRL 12'h008
`define OCR_ADDR_FREQ_A 12'h00C
`define OCR_ADDR_FREQ_B 12'h010
`define OCR_ADDR_FREQ_C 12'h014
`define OCR_ADDR_FREQ_D 12'h018
`define OCR_ADDR_FREQ_E 12'h01C
`define OCR_ADDR_FREQ_F 12'h020
`define OCR_ADDR_FREQ_G 12'h024
`define OCR_ADDR_STATUS 12'h028
`define OCR_ADDR_GPIO 12'h02C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OCR_FS_8K_INV 0
`define OCR_FS_8K_PUL 1
`define OCR_FS_2K_INV 2
`define OCR_FS_2K_PUL 3

// ----------------------------------------------------------------
// Reset values (frequencies in kHz, formats 2'b00 = LVDS)
// ----------------------------------------------------------------
`define OCR_FMT_LVDS 2'h0
`define OCR_FMT_RESET 8'h00
`define OCR_DUP_RESET 5'h00
`define OCR_FS_RESET 4'h0
`define OCR_FREQ_A_RST 20'h01950
`define OCR_FREQ_B_RST 20'h097E0
`define OCR_FREQ_C_RST 20'h04BF0
`define OCR_FREQ_D_RST 20'h097E0
`define OCR_FREQ_E_SONET 20'h00608
`define OCR_FREQ_E_SDH 20'h00800
`define OCR_FREQ_F_RST 20'h097E0
`define OCR_FREQ_G_RST 20'h04BF0

// ----------------------------------------------------------------
// Frame-sync timing (8 kHz period 125000 ns, 2 kHz 4x that)
// ----------------------------------------------------------------
`define OCR_CLK_NS 10
`define OCR_FS8K_PERIOD_NS 125000
`define OCR_FS8K_CYCLES (`OCR_FS8K_PERIOD_NS / `OCR_CLK_NS)
`define OCR_FS_MF_RATIO 4
`define OCR_FS8K_LAST 14'h30D3
`define OCR_FS8K_HALF 14'h186A
`define OCR_FS_MF_LAST 2'h3

`endif

// >>> hdl/ocr_frame_sync.v
// Frame-sync shaper: 50% clock or one-cycle pulse, optional inversion.
// Assumes period_start marks the period start and second_half the later half.
`timescale 1ns/1ps

module ocr_frame_sync (
	input wire ref_clk, // System clock
	input wire sys_rst, // Synchronous reset, high
	input wire period_start, // One-cycle pulse at period start
	input wire second_half, // Level, high in second half of period
	input wire invert, // Invert polarity
	input wire pulse_mode, // Pulse instead of clock
	output reg sync_out // Shaped sync output
);

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			sync_out <= 1'b0;
		end else if (pulse_mode) begin
			sync_out <= period_start ^ invert;
		end else begin
			sync_out <= (~second_half) ^ invert;
		end
	end

endmodule // ocr_frame_sync

// >>> sim/ocr_stage_checker.sv
// Concurrent checks on the pins of the output stage.
// Assumes one ref_clk domain and a synchronous, active-high sys_rst.
`timescale 1ns/1ps

module ocr_stage_checker (
	input wire ref_clk, // clock
	input wire sys_rst, // reset
	input wire [6:0] synth_clk, // sources
	input wire clk_out_a, // pin
	input wire clk_out_b, // pin
	input wire clk_out_c, // pin
	input wire clk_out_d, // pin
	input wire clk_out_e, // pin
	input wire clk_out_d_diff_p, // pin
	input wire clk_out_d_diff_n, // pin
	input wire clk_out_e_diff_p, // pin
	input wire clk_out_e_diff_n, // pin
	input wire clk_out_f_diff_p, // pin
	input wire clk_out_f_diff_n, // pin
	input wire clk_out_g_diff_p, // pin
	input wire clk_out_g_diff_n, // pin
	input wire [2:0] aux_io_oe, // enables
	input wire clk_out_d_dup, // pin
	input wire clk_out_d_dup_oe, // enable
	input wire clk_out_e_dup, // pin
	input wire clk_out_e_dup_oe, // enable
	input wire frame_sync_out, // pin
	input wire multiframe_sync_out // pin
);
	// ----------------------------------------
	// Warm-up count: clock path is 3 deep
	// ----------------------------------------
	reg [1:0] warm;
	always @(posedge ref_clk) begin
		if (sys_rst)
			warm <= 2'h0;
		else if (warm != 2'h3)
			warm <= warm + 2'h1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_se_lag: assert property (
		warm == 2'h3 |-> {clk_out_e, clk_out_d, clk_out_c, clk_out_b, clk_out_a} == $past(synth_clk[4:0], 3))
		else $error("single-ended clock lag wrong");
	a_diff_d_mirror: assert property (
		clk_out_d_diff_p == clk_out_d && clk_out_d_diff_n != clk_out_d_diff_p) else $error("diff d mismatch");
	a_diff_e_mirror: assert property (
		clk_out_e_diff_p == clk_out_e && clk_out_e_diff_n != clk_out_e_diff_p) else $error("diff e mismatch");
	a_diff_f_lag: assert property (
		warm == 2'h3 |-> clk_out_f_diff_p == $past(synth_clk[5], 3) && clk_out_f_diff_n != clk_out_f_diff_p)
		else $error("diff f wrong");
	a_diff_g_lag: assert property (
		warm == 2'h3 |-> clk_out_g_diff_p == $past(synth_clk[6], 3) && clk_out_g_diff_n != clk_out_g_diff_p)
		else $error("diff g wrong");
	a_dup_d_follow: assert property (clk_out_d_dup_oe |-> clk_out_d_dup == clk_out_d)
		else $error("dup d not following");
	a_dup_e_follow: assert property (clk_out_e_dup_oe |-> clk_out_e_dup == clk_out_e)
		else $error("dup e not following");
	a_dup_off_quiet: assert property (
		(clk_out_d_dup_oe || !clk_out_d_dup) && (clk_out_e_dup_oe || !clk_out_e_dup))
		else $error("disabled dup toggling");
	a_reset_quiet: assert property (
		$past(sys_rst) |-> !clk_out_d_dup_oe && !clk_out_e_dup_oe && aux_io_oe == 3'h0 && !frame_sync_out)
		else $error("outputs active after reset");
	cover property (clk_out_d_dup_oe && clk_out_e_dup_oe);
	cover property (aux_io_oe == 3'h7);
	cover property ($fell(multiframe_sync_out));
endmodule // ocr_stage_checker

bind ocr_output_stage ocr_stage_checker u_chk (.ref_clk, .sys_rst, .synth_clk, .clk_out_a, .clk_out_b, .clk_out_c,
	.clk_out_d, .clk_out_e, .clk_out_d_diff_p, .clk_out_d_diff_n, .clk_out_e_diff_p, .clk_out_e_diff_n,
	.clk_out_f_diff_p, .clk_out_f_diff_n, .clk_out_g_diff_p, .clk_out_g_diff_n, .aux_io_oe, .clk_out_d_dup,
	.clk_out_d_dup_oe, .clk_out_e_dup, .clk_out_e_dup_oe, .frame_sync_out, .multiframe_sync_out);

// >>> sim/ocr_board_model.sv
// Board-side model of the three shared auxiliary pins.
// Assumes pull-ups on the board and an optional external driver per pin.
`timescale 1ns/1ps

module ocr_board_model (
	input wire [2:0] aux_io_out, // device drive
	input wire [2:0] aux_io_oe, // device enable
	input wire [2:0] ext_en, // board driver on
	input wire [2:0] ext_val, // board driver value
	output wire [2:0] aux_level // pin level
);
	// Pull-up keeps a released pin from showing a stale level
	assign aux_level = (aux_io_oe & aux_io_out) | (~aux_io_oe & ext_en & ext_val) | (~aux_io_oe & ~ext_en);
endmodule // ocr_board_model

// >>> sim/output_clock_pin_routing_test.sv
// Self-checking bench for the output clock pin routing block.
// Assumes zero-wait APB and the register map of the shared header.
`timescale 1ns/1ps
`include "ocr_defs.vh"

module output_clock_pin_routing_test;
	logic ref_clk, sys_rst, psel, penable, pwrite, rate_family_select, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic clk_out_a, clk_out_b, clk_out_c, clk_out_d, clk_out_e, clk_out_d_diff_p, clk_out_d_diff_n;
	logic clk_out_e_diff_p, clk_out_e_diff_n, clk_out_f_diff_p, clk_out_f_diff_n, clk_out_g_diff_p, clk_out_g_diff_n;
	logic [1:0] diff_d_format, diff_e_format, diff_f_format, diff_g_format;
	logic [19:0] freq_a, freq_b, freq_c, freq_d, freq_e, freq_f, freq_g;
	logic [6:0] synth_clk, d1, d2, d3;
	logic [2:0] aux_io_in, aux_io_out, aux_io_oe, ext_en, ext_val;
	logic clk_out_d_dup, clk_out_d_dup_oe, clk_out_e_dup, clk_out_e_dup_oe, frame_sync_out, multiframe_sync_out;
	logic [7:0] pat;
	logic [19:0] exp_f [0:6];
	integer error_cnt = 0, compares = 0, n, i;

	ocr_output_stage uut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rate_family_select, .synth_clk, .clk_out_a, .clk_out_b, .clk_out_c, .clk_out_d, .clk_out_e,
		.clk_out_d_diff_p, .clk_out_d_diff_n, .clk_out_e_diff_p, .clk_out_e_diff_n, .clk_out_f_diff_p,
		.clk_out_f_diff_n, .clk_out_g_diff_p, .clk_out_g_diff_n, .diff_d_format, .diff_e_format, .diff_f_format,
		.diff_g_format, .freq_a, .freq_b, .freq_c, .freq_d, .freq_e, .freq_f, .freq_g, .aux_io_in, .aux_io_out,
		.aux_io_oe, .clk_out_d_dup, .clk_out_d_dup_oe, .clk_out_e_dup, .clk_out_e_dup_oe, .frame_sync_out,
		.multiframe_sync_out);
	ocr_board_model board (.aux_io_out, .aux_io_oe, .ext_en, .ext_val, .aux_level(aux_io_in));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Free-running counter bits give seven clock rates, each half of the one below; d3 is the expected pin value
	always @(posedge ref_clk) begin
		synth_clk <= synth_clk + 7'h01;
		d1 <= synth_clk;
		d2 <= d1;
		d3 <= d2;
	end
	initial begin
		repeat (70000) @(posedge ref_clk);
		error_cnt++;
		stop_test;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task stop_test;
		if (error_cnt == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask
	task run_len(input logic mf, input logic lvl);
		n = 0;
		while ((mf ? multiframe_sync_out : frame_sync_out) === lvl && n < 60000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask
	task do_reset(input logic strap);
		rate_family_select <= strap;
		sys_rst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		{synth_clk, d1, d2, d3, ext_en, ext_val, rate_family_select} = {34'h0, 1'b1};
		exp_f = '{20'h01950, 20'h097E0, 20'h04BF0, 20'h097E0, 20'h00608, 20'h097E0, 20'h04BF0};
		do_reset(1'b1);
		#1;
		run_len(1'b0, 1'b1);
		run_len(1'b0, 1'b0);
		chk(n, 6250);
		run_len(1'b1, 1'b1);
		chk(n, 12500);
		chk(frame_sync_out, 1'b1);
		run_len(1'b0, 1'b1);
		chk(n, 6250);
		for (i = 0; i < 7; i++) begin
			apb(1'b0, `OCR_ADDR_FREQ_A + 12'h004 * i[11:0], 32'h0);
			chk(rd, {12'h000, exp_f[i]});
		end
		chk(freq_b, {12'h000, exp_f[1]});
		chk(freq_c, {12'h000, exp_f[2]});
		chk(freq_d, {12'h000, exp_f[3]});
		chk(freq_e, {12'h000, exp_f[4]});
		chk(freq_f, {12'h000, exp_f[5]});
		chk(freq_g, {12'h000, exp_f[6]});
		chk({diff_g_format, diff_f_format, diff_e_format, diff_d_format, aux_io_oe, clk_out_d_dup_oe}, 0);
		for (i = 0; i < 4; i++) begin
			pat = {i[1:0] + 2'h3, i[1:0] + 2'h2, i[1:0] + 2'h1, i[1:0]};
			apb(1'b1, `OCR_ADDR_FMT_CTRL, {24'h0, pat});
			chk({diff_g_format, diff_f_format, diff_e_format, diff_d_format}, pat);
		end
		apb(1'b1, `OCR_ADDR_FREQ_A, 32'h00002710);
		chk(freq_a, 32'h00002710);
		apb(1'b1, 12'h030, 32'hFFFFFFFF);
		apb(1'b0, 12'h030, 32'h0);
		chk(rd, 32'h0);
		chk({pready, pslverr}, 32'h2);
		ext_en <= 3'h4;
		apb(1'b1, `OCR_ADDR_GPIO, 32'h00000023);
		repeat (4) @(posedge ref_clk);
		chk({aux_io_oe, aux_io_out[1:0]}, {3'h3, 2'h2});
		apb(1'b0, `OCR_ADDR_STATUS, 32'h0);
		chk(rd, 32'h00000005);
		apb(1'b1, `OCR_ADDR_DUP_CTRL, 32'h0000001F);
		for (i = 0; i < 40; i++) begin
			@(posedge ref_clk);
			#1;
			chk({clk_out_e, clk_out_d, clk_out_c, clk_out_b, clk_out_a}, d3[4:0]);
			chk({aux_io_oe, aux_io_out}, {3'h7, d3[2:0]});
			chk({clk_out_e_dup_oe, clk_out_e_dup, clk_out_d_dup_oe, clk_out_d_dup}, {1'b1, d3[4], 1'b1, d3[3]});
			chk({clk_out_e_diff_p, clk_out_e_diff_n, clk_out_d_diff_p, clk_out_d_diff_n}, {d3[4], ~d3[4], d3[3], ~d3[3]});
			chk({clk_out_g_diff_p, clk_out_g_diff_n, clk_out_f_diff_p, clk_out_f_diff_n}, {d3[6], ~d3[6], d3[5], ~d3[5]});
		end
		apb(1'b1, `OCR_ADDR_DUP_CTRL, 32'h0);
		chk({aux_io_oe, clk_out_e_dup_oe, clk_out_d_dup_oe, clk_out_e_dup, clk_out_d_dup}, {3'h3, 4'h0});
		apb(1'b1, `OCR_ADDR_FS_CTRL, 32'h0000000F);
		#1;
		run_len(1'b1, 1'b1);
		chk({frame_sync_out, multiframe_sync_out}, 2'h0);
		run_len(1'b1, 1'b0);
		chk(n, 1);
		chk(frame_sync_out, 1'b1);
		@(posedge ref_clk);
		do_reset(1'b0);
		apb(1'b0, `OCR_ADDR_STATUS, 32'h0);
		chk(rd[0], 1'b0);
		chk(freq_e, 32'h00000800);
		chk({clk_out_e_dup_oe, clk_out_d_dup_oe, aux_io_oe}, 0);
		stop_test;
	end
endmodule // output_clock_pin_routing_test
